// >>> core/wwds_top.sv
// Windowed watchdog with APB register access and key-sequence service
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module wwds_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [wwds_pkg::WWDS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic internalRcClock,
	input wire logic oscillatorClock,
	input wire logic backgroundDebugState,
	input wire logic specialMode,
	output logic watchdogReset
);
	logic [1:0] rstSync;
	logic rstN;

	// Period length for a select code, 2^exp
	function automatic logic [24:0] wwdsPeriodLen(input logic [2:0] sel);
		logic [4:0] e;
		e = wwds_pkg::WWDS_EXP_SEL7;
		case (sel)
			3'h1: e = wwds_pkg::WWDS_EXP_SEL1;
			3'h2: e = wwds_pkg::WWDS_EXP_SEL2;
			3'h3: e = wwds_pkg::WWDS_EXP_SEL3;
			3'h4: e = wwds_pkg::WWDS_EXP_SEL4;
			3'h5: e = wwds_pkg::WWDS_EXP_SEL5;
			3'h6: e = wwds_pkg::WWDS_EXP_SEL6;
			default: e = wwds_pkg::WWDS_EXP_SEL7;
		endcase
		return 25'h1 << e;
	endfunction

	function automatic logic [11:0] wwdsByteAddr(input logic [9:0] idx);
		return {idx, 2'h0};
	endfunction

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'h1};
		end
	end
	assign rstN = rstSync[1];

	// Pin synchronisers: three stages, change taken when stages two and three agree
	logic [2:0] rcSync, oscSync, dbgSync, spcSync;
	logic rcStable, oscStable, dbgStable, spcStable;
	logic next_rcStable, next_oscStable;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rcSync <= 3'h0;
			oscSync <= 3'h0;
			dbgSync <= 3'h0;
			spcSync <= 3'h0;
		end else begin
			rcSync <= {rcSync[1:0], internalRcClock};
			oscSync <= {oscSync[1:0], oscillatorClock};
			dbgSync <= {dbgSync[1:0], backgroundDebugState};
			spcSync <= {spcSync[1:0], specialMode};
		end
	end

	assign next_rcStable = (rcSync[1] == rcSync[2]) ? rcSync[2] : rcStable;
	assign next_oscStable = (oscSync[1] == oscSync[2]) ? oscSync[2] : oscStable;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rcStable <= 1'h0;
			oscStable <= 1'h0;
			dbgStable <= 1'h0;
			spcStable <= 1'h0;
		end else begin
			rcStable <= next_rcStable;
			oscStable <= next_oscStable;
			dbgStable <= (dbgSync[1] == dbgSync[2]) ? dbgSync[2] : dbgStable;
			spcStable <= (spcSync[1] == spcSync[2]) ? spcSync[2] : spcStable;
		end
	end

	// Control state
	logic [2:0] periodSelect;
	logic watchdogSourceSelect;
	logic haltInDebug;
	logic windowModeEnable;
	logic armed;
	logic [wwds_pkg::WWDS_CNT_W-1:0] count;

	// APB decode
	wire setupPhase = psel & ~penable;
	wire writeAccess = psel & penable & pready & pwrite;
	wire hitControl = paddr == wwdsByteAddr(wwds_pkg::WWDS_IDX_CONTROL);
	wire hitService = paddr == wwdsByteAddr(wwds_pkg::WWDS_IDX_SERVICE);
	wire hitStatus = paddr == wwdsByteAddr(wwds_pkg::WWDS_IDX_STATUS);
	wire mapped = hitControl | hitService | hitStatus;
	wire controlWrite = writeAccess & hitControl;
	wire serviceWrite = writeAccess & hitService;
	wire [7:0] serviceValue = pwdata[7:0];

	// Watchdog operating terms
	wire enabled = periodSelect != 3'h0;
	wire debugOverride = enabled & dbgStable & ~haltInDebug & spcStable;
	wire [2:0] effSelect = debugOverride ? wwds_pkg::WWDS_SEL_LONGEST : periodSelect;
	wire windowActive = windowModeEnable & ~debugOverride;
	wire [24:0] periodLen = wwdsPeriodLen(effSelect);
	wire [24:0] lastCount25 = periodLen - 25'h1;
	wire [24:0] windowStart25 = periodLen - (periodLen >> 2);
	wire [wwds_pkg::WWDS_CNT_W-1:0] lastCount = lastCount25[23:0];
	wire windowOpen = {1'h0, count} >= windowStart25;
	wire stopped = haltInDebug & dbgStable;

	// Rising edge of the chosen watchdog clock; source must be well below clk / 4
	wire rcRise = next_rcStable & ~rcStable;
	wire oscRise = next_oscStable & ~oscStable;
	wire srcRise = watchdogSourceSelect ? oscRise : rcRise;
	wire tick = enabled & srcRise & ~stopped;
	// At or past the end: a period shortened on leaving debug still expires
	wire timeoutNow = tick & (count >= lastCount);

	// Service sequence evaluation; a disabled watchdog sees nothing
	wire serviceLive = serviceWrite & enabled;
	wire isArmKey = serviceValue == wwds_pkg::WWDS_KEY_ARM;
	wire isRestartKey = serviceValue == wwds_pkg::WWDS_KEY_RESTART;
	wire badValue = serviceLive & ~isArmKey & ~isRestartKey;
	wire earlyWrite = serviceLive & windowActive & ~windowOpen;
	wire badWrite = badValue | earlyWrite;
	wire armWrite = serviceLive & isArmKey & ~earlyWrite;
	wire serviceAccept = serviceLive & isRestartKey & armed & ~earlyWrite;

	// Control load restarts the period when a nonzero select or new source lands
	wire [2:0] newSelect = pwdata[wwds_pkg::WWDS_CTL_SEL_LSB +: 3];
	wire newSource = pwdata[wwds_pkg::WWDS_CTL_SRC_BIT];
	wire loadRestart = controlWrite & ((newSelect != 3'h0) | (newSource != watchdogSourceSelect));

	// An accepted sequence beats a timeout in the same cycle
	wire next_watchdogReset = badWrite | (timeoutNow & ~serviceAccept);
	wire restart = serviceAccept | loadRestart | badWrite | timeoutNow;
	wire [wwds_pkg::WWDS_CNT_W-1:0] next_count = restart ? '0 : (tick ? count + 24'h1 : count);
	// An arm write landing with a timeout still arms the fresh period
	wire next_armed = armWrite ? 1'h1 : ((restart | ~enabled) ? 1'h0 : armed);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			count <= '0;
			armed <= 1'h0;
			watchdogReset <= 1'h0;
		end else begin
			count <= next_count;
			armed <= next_armed;
			watchdogReset <= next_watchdogReset;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			periodSelect <= wwds_pkg::WWDS_SEL_RESET;
			watchdogSourceSelect <= wwds_pkg::WWDS_SRC_RESET;
			haltInDebug <= wwds_pkg::WWDS_HALT_RESET;
			windowModeEnable <= wwds_pkg::WWDS_WIN_RESET;
		end else if (controlWrite) begin
			periodSelect <= newSelect;
			watchdogSourceSelect <= newSource;
			haltInDebug <= pwdata[wwds_pkg::WWDS_CTL_HALT_BIT];
			windowModeEnable <= pwdata[wwds_pkg::WWDS_CTL_WIN_BIT];
		end
	end

	// Read data, built during the setup cycle so the access phase has no wait
	wire [31:0] controlRead = {24'h0, windowModeEnable, haltInDebug, 2'h0,
		watchdogSourceSelect, periodSelect};
	wire [31:0] statusRead = {count, 4'h0, debugOverride, windowOpen, armed, enabled};
	wire [31:0] serviceRead = {24'h0, wwds_pkg::WWDS_SERVICE_READ};
	wire [31:0] readMux = hitControl ? controlRead :
		(hitStatus ? statusRead : (hitService ? serviceRead : 32'h0));

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h0;
		end else begin
			pready <= setupPhase;
			pslverr <= setupPhase & ~mapped;
			prdata <= (setupPhase & ~pwrite) ? readMux : 32'h0;
		end
	end

	// Checks
	bad_value_reset_a: assert property (@(posedge clk) disable iff (!rstN)
		(serviceWrite && enabled && !isArmKey && !isRestartKey) |=> watchdogReset)
		else $error("bad service value did not reset");

	disabled_ignore_a: assert property (@(posedge clk) disable iff (!rstN)
		(serviceWrite && periodSelect == 3'h0 && !timeoutNow) |=> !watchdogReset)
		else $error("write while disabled caused reset");

	service_reads_zero_a: assert property (@(posedge clk) disable iff (!rstN)
		(setupPhase && !pwrite && hitService) |=> (pready && prdata == 32'h0))
		else $error("service register read nonzero");

	key_restart_a: assert property (@(posedge clk) disable iff (!rstN)
		(serviceWrite && enabled && isRestartKey && armed && !earlyWrite)
		|=> (count == 24'h0 && !armed && !watchdogReset))
		else $error("accepted sequence did not restart");

	lone_restart_a: assert property (@(posedge clk) disable iff (!rstN)
		(serviceWrite && isRestartKey && !armed && !timeoutNow && !earlyWrite && !tick)
		|=> count == $past(count))
		else $error("restart key without arm restarted period");

	early_window_a: assert property (@(posedge clk) disable iff (!rstN)
		(serviceWrite && enabled && windowActive && !windowOpen) |=> watchdogReset)
		else $error("early write in window mode did not reset");

	repeat_arm_a: assert property (@(posedge clk) disable iff (!rstN)
		(serviceWrite && enabled && isArmKey && !earlyWrite && !timeoutNow)
		|=> (armed && !watchdogReset))
		else $error("arm write penalised");

	timeout_reset_a: assert property (@(posedge clk) disable iff (!rstN)
		(tick && count == lastCount && !serviceAccept) |=> (watchdogReset && count == 24'h0))
		else $error("timeout did not reset");

	load_restart_a: assert property (@(posedge clk) disable iff (!rstN)
		(controlWrite && newSelect != 3'h0) |=> (count == 24'h0 && enabled))
		else $error("nonzero select did not restart");

	debug_longest_a: assert property (@(posedge clk) disable iff (!rstN)
		(enabled && dbgStable && !haltInDebug && spcStable)
		|-> (lastCount == 24'hffffff && !windowActive))
		else $error("debug override not at longest period");

	period_len_a: assert property (@(posedge clk) disable iff (!rstN)
		(enabled && !debugOverride && periodSelect == 3'h1) |-> lastCount == 24'h003fff)
		else $error("select one period wrong");

	source_tick_a: assert property (@(posedge clk) disable iff (!rstN)
		(enabled && !stopped && !restart && !watchdogSourceSelect && rcRise)
		|=> count == $past(count) + 24'h1)
		else $error("selected source did not advance counter");

	// Clock source and period checks
	osc_tick_a: assert property (@(posedge clk) disable iff (!rstN)
		(enabled && !stopped && !restart && watchdogSourceSelect && oscRise)
		|=> count == $past(count) + 24'h1)
		else $error("oscillator source did not advance counter");

	source_change_a: assert property (@(posedge clk) disable iff (!rstN)
		(controlWrite && newSource != watchdogSourceSelect) |=> count == 24'h0)
		else $error("source change did not restart period");

	disabled_frozen_a: assert property (@(posedge clk) disable iff (!rstN)
		(!enabled && !controlWrite) |=> count == $past(count))
		else $error("counter moved while disabled");

	// Service sequence and window checks
	disabled_arm_a: assert property (@(posedge clk) disable iff (!rstN)
		(serviceWrite && !enabled) |=> !armed)
		else $error("write while disabled armed the sequence");

	bad_write_clear_a: assert property (@(posedge clk) disable iff (!rstN)
		(serviceWrite && enabled && !isArmKey && !isRestartKey) |=> (!armed && count == 24'h0))
		else $error("bad service write left sequence armed");

	window_accept_a: assert property (@(posedge clk) disable iff (!rstN)
		(serviceWrite && enabled && windowActive && windowOpen && isArmKey && !timeoutNow)
		|=> (armed && !watchdogReset))
		else $error("arm write inside open window penalised");

	restart_window_a: assert property (@(posedge clk) disable iff (!rstN)
		serviceAccept |=> (count == 24'h0 && !windowOpen))
		else $error("window not closed after accepted sequence");

	load_arm_clear_a: assert property (@(posedge clk) disable iff (!rstN)
		(controlWrite && newSelect != 3'h0) |=> !armed)
		else $error("select load left sequence armed");

	// Bus and debug checks
	halt_freeze_a: assert property (@(posedge clk) disable iff (!rstN)
		(stopped && !restart) |=> count == $past(count))
		else $error("counter advanced while halted in debug");

	access_ready_a: assert property (@(posedge clk) disable iff (!rstN)
		setupPhase |=> pready)
		else $error("access phase not answered at once");
endmodule

// >>> core/wwds_pkg.sv
// Constants shared by the windowed watchdog service block
package wwds_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] WWDS_IDX_CONTROL = 10'h03c;
	localparam logic [9:0] WWDS_IDX_SERVICE = 10'h03f;
	localparam logic [9:0] WWDS_IDX_STATUS = 10'h040;
	localparam int WWDS_ADDR_W = 12;
	// Control register fields
	localparam int WWDS_CTL_SEL_LSB = 0;
	localparam int WWDS_CTL_SRC_BIT = 3;
	localparam int WWDS_CTL_HALT_BIT = 6;
	localparam int WWDS_CTL_WIN_BIT = 7;
	localparam logic [2:0] WWDS_SEL_RESET = 3'h0;
	localparam logic WWDS_SRC_RESET = 1'h0;
	localparam logic WWDS_HALT_RESET = 1'h0;
	localparam logic WWDS_WIN_RESET = 1'h0;
	// Status register fields
	localparam int WWDS_STA_EN_BIT = 0;
	localparam int WWDS_STA_ARM_BIT = 1;
	localparam int WWDS_STA_WIN_BIT = 2;
	localparam int WWDS_STA_OVR_BIT = 3;
	localparam int WWDS_STA_CNT_LSB = 8;
	// Service sequence values
	localparam logic [7:0] WWDS_KEY_ARM = 8'h55;
	localparam logic [7:0] WWDS_KEY_RESTART = 8'haa;
	localparam logic [7:0] WWDS_SERVICE_READ = 8'h00;
	// Period exponents per select code
	localparam logic [4:0] WWDS_EXP_SEL1 = 5'h0e;
	localparam logic [4:0] WWDS_EXP_SEL2 = 5'h10;
	localparam logic [4:0] WWDS_EXP_SEL3 = 5'h12;
	localparam logic [4:0] WWDS_EXP_SEL4 = 5'h14;
	localparam logic [4:0] WWDS_EXP_SEL5 = 5'h16;
	localparam logic [4:0] WWDS_EXP_SEL6 = 5'h17;
	localparam logic [4:0] WWDS_EXP_SEL7 = 5'h18;
	localparam logic [2:0] WWDS_SEL_LONGEST = 3'h7;
	localparam int WWDS_CNT_W = 24;
endpackage

// >>> sim/testbench.sv
// Self-checking testbench for the windowed watchdog service block
`timescale 1ns/1ps
module testbench;
	localparam logic [11:0] CTRL = {wwds_pkg::WWDS_IDX_CONTROL, 2'b00};
	localparam logic [11:0] SERV = {wwds_pkg::WWDS_IDX_SERVICE, 2'b00};
	localparam logic [11:0] STAT = {wwds_pkg::WWDS_IDX_STATUS, 2'b00};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic internalRcClock = 1'b0;
	logic oscillatorClock = 1'b0;
	logic backgroundDebugState = 1'b0;
	logic specialMode = 1'b0;
	logic watchdogReset;
	logic oscRun = 1'b0;
	int divCount = 0;
	int n_fail = 0;
	int samples_checked = 0;
	int waitCycles;
	logic [31:0] badValue;
	logic [64:0] apbQ[$];
	logic rstQ[$];

	wwds_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.internalRcClock(internalRcClock), .oscillatorClock(oscillatorClock),
		.backgroundDebugState(backgroundDebugState), .specialMode(specialMode),
		.watchdogReset(watchdogReset));

	initial forever #5 clk = ~clk;

	// Source clocks at clk/5; oscillator held still unless enabled
	always @(posedge clk) begin
		divCount <= (divCount == 4) ? 0 : divCount + 1;
		internalRcClock <= (divCount < 2);
		oscillatorClock <= oscRun && (divCount < 2);
	end

	task chkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task chkBit(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask

	// Results are compared as they appear, against the oldest note
	always @(posedge clk) begin
		logic [64:0] e;
		if (pready === 1'b1) begin
			e = apbQ.pop_front();
			chkWord("read data", e[31:0], prdata & e[63:32]);
			chkBit("slave error", e[64], pslverr);
		end
		if (watchdogReset === 1'b1) begin
			chkBit("watchdog reset", (rstQ.size() > 0) ? rstQ.pop_front() : 1'b0, 1'b1);
		end
	end

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] exp, input logic err);
		apbQ.push_back({err, m, exp & m});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h00000000, 32'h00000000, 1'b0);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000, m, exp, 1'b0);
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Longest path is one full short period of about 82k cycles
	initial begin
		#950000;
		n_fail++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'haa4e));
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		rd(SERV, 32'hffffffff, 32'h00000000);
		apb(1'b0, 12'h004, 32'h00000000, 32'hffffffff, 32'h00000000, 1'b1);
		wr(SERV, 32'h00000013);
		rd(STAT, 32'h00000001, 32'h00000000);
		wr(CTRL, 32'h00000009);
		repeat (40) @(posedge clk);
		rd(STAT, 32'hffffff01, 32'h00000001);
		oscRun <= 1'b1;
		wr(CTRL, 32'h00000001);
		wr(SERV, 32'h000000aa);
		wr(SERV, 32'h00000055);
		rd(STAT, 32'h00000002, 32'h00000002);
		wr(SERV, 32'h00000055);
		wr(SERV, 32'h000000aa);
		rd(STAT, 32'h00000002, 32'h00000000);
		// Oscillator source in window mode: one late arm write, no restart
		wr(CTRL, 32'h00000089);
		waitCycles = 0;
		rstQ.push_back(1'b1);
		while (watchdogReset !== 1'b1 && waitCycles < 90000) begin
			if (waitCycles == 70000) begin
				wr(SERV, 32'h00000055);
				waitCycles += 3;
			end
			@(posedge clk);
			waitCycles++;
		end
		chkBit("period length", 1'b1, waitCycles > 81850 && waitCycles < 82000);
		wr(CTRL, 32'h00000001);
		badValue = $urandom();
		if (badValue[7:0] == 8'h55 || badValue[7:0] == 8'haa) badValue[0] = ~badValue[0];
		rstQ.push_back(1'b1);
		wr(SERV, badValue);
		wr(CTRL, 32'h00000081);
		rstQ.push_back(1'b1);
		wr(SERV, 32'h00000055);
		backgroundDebugState <= 1'b1;
		specialMode <= 1'b1;
		wr(CTRL, 32'h00000081);
		repeat (8) @(posedge clk);
		rd(STAT, 32'h00000008, 32'h00000008);
		wr(SERV, 32'h00000055);
		rd(STAT, 32'h00000002, 32'h00000002);
		// Halt in debug: override off and the counter held at its restart value
		wr(CTRL, 32'h00000041);
		repeat (40) @(posedge clk);
		rd(STAT, 32'hffffff08, 32'h00000000);
		repeat (20) @(posedge clk);
		chkBit("missing resets", 1'b0, rstQ.size() > 0);
		wrap_up();
	end
endmodule
